// >>> pkg/lhcd_pkg.sv
// constants and types of the display host command decoder
package lhcd_pkg;

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_OVERLAY   = 8'h5b;
  localparam logic [7:0] CMD_DISP_OFF  = 8'h58;
  localparam logic [7:0] CMD_DISP_ON   = 8'h59;
  localparam logic [7:0] CMD_CSR_WRITE = 8'h46;
  localparam logic [7:0] CMD_CURSOR_SHAPE_CMD  = 8'h5d;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
  // direction commands are 4ch..4fh, direction in the low two bits
  localparam logic [7:0] CMD_DIR_BASE  = 8'h4c;
  localparam logic [7:0] CMD_DIR_MASK  = 8'hfc;

  // ------------------------------------------------------------
  // register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DISPLAY_ENABLE     = 8'h09;
  localparam logic [7:0] OFS_DISPLAY_ATTRIBUTES = 8'h0a;
  localparam logic [7:0] OFS_CURSOR_WIDTH       = 8'h15;
  localparam logic [7:0] OFS_CURSOR_HEIGHT      = 8'h16;
  localparam logic [7:0] OFS_CURSOR_DIRECTION   = 8'h17;
  localparam logic [7:0] OFS_LAYER_OVERLAY      = 8'h18;
  localparam logic [7:0] OFS_CURSOR_ADDR_LOW    = 8'h1c;
  localparam logic [7:0] OFS_CURSOR_ADDR_HIGH   = 8'h1d;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ------------------------------------------------------------
  // field positions and encodings
  // ------------------------------------------------------------
  localparam int DISP_EN_BIT      = 0;
  localparam int COMBINE_LSB      = 0;
  localparam int BLOCK1_TEXT_BIT  = 2;
  localparam int BLOCK3_TEXT_BIT  = 3;
  localparam int BLINK_LSB        = 0;
  localparam int BLOCK1_EN_LSB    = 2;
  localparam int BLOCK2_4_EN_LSB  = 4;
  localparam int BLOCK3_EN_LSB    = 6;
  localparam int SIZE_LSB         = 0;
  localparam int BLOCK_CURSOR_BIT = 7;
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT  = 2'h1;
  localparam logic [1:0] DIR_UP    = 2'h2;
  localparam logic [1:0] DIR_DOWN  = 2'h3;
  localparam logic [1:0] BLINK_OFF    = 2'h0;
  localparam logic [1:0] BLINK_STEADY = 2'h1;
  localparam logic [1:0] BLINK_FAST   = 2'h2;
  localparam logic [1:0] BLINK_SLOW   = 2'h3;

  // ------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------
  localparam int BYTE_W        = 8;
  localparam int FIFO_DEPTH    = 32;
  localparam int CLK_PERIOD_NS = 10;
  // half period of the 2 hz flash
  localparam int BLINK_HALF_NS = 250000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_MWR   = 2'b10
  } lhcd_state_t;

endpackage : lhcd_pkg

// >>> tb/lhcd_decoder_tb.sv
// self-checking bench of the display host command decoder
`timescale 1ns/100ps
module lhcd_decoder_tb;
  logic        clk, rstn, host_wr, host_cmd_sel, host_ready, hold;
  logic        mem_wr_valid, mem_wr_ready, cursor_visible;
  logic [7:0]  host_data, mem_wr_data, display_enable, display_attributes;
  logic [7:0]  cursor_width, cursor_height_style, cursor_direction;
  logic [7:0]  layer_overlay, cursor_address_low, cursor_address_high;
  logic [15:0] line_pitch, mem_wr_addr, cur;
  logic [23:0] exp_q[$];
  logic [7:0]  b, v;
  integer      seed = 69535;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  bit          saw_full = 0;

  lhcd_decoder #(.BLINK_HALF_CYC(4), .FIFO_DEPTH(lhcd_pkg::FIFO_DEPTH)) uut (
    .clk, .rstn, .host_wr, .host_cmd_sel, .host_data, .host_ready,
    .line_pitch, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready,
    .display_enable, .display_attributes, .cursor_width,
    .cursor_height_style, .cursor_direction, .layer_overlay,
    .cursor_address_low, .cursor_address_high, .cursor_visible);

  lhcd_mem_model #(.SEED(69535)) mem (.clk, .rstn, .hold, .mem_wr_ready);

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // called and left one step after an edge; held until taken
  task automatic send(input logic c, input logic [7:0] d);
    host_wr = 1'b1;
    host_cmd_sel = c;
    host_data = d;
    while (host_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : send

  task automatic idle(input int n);
    host_wr = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic mwr(input logic [1:0] d, input int n, input bit rnd,
                     input logic [7:0] f);
    cur = 16'($random(seed));
    send(1'b1, lhcd_pkg::CMD_CSR_WRITE);
    send(1'b0, cur[7:0]);
    send(1'b0, cur[15:8]);
    send(1'b1, lhcd_pkg::CMD_DIR_BASE | {6'h00, d});
    send(1'b1, lhcd_pkg::CMD_MEM_WRITE);
    for (int i = 0; i < n; i++) begin
      b = rnd ? 8'($random(seed)) : f;
      exp_q.push_back({cur, b});
      case (d)
        2'h0: cur = cur + 16'h0001;
        2'h1: cur = cur - 16'h0001;
        2'h2: cur = cur - line_pitch;
        default: cur = cur + line_pitch;
      endcase
      send(1'b0, b);
    end
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) idle(1);
    idle(2);
    chk("cursor", {8'h00, cur}, {8'h00, cursor_address_high, cursor_address_low});
    chk("writes left", 24'h0, 24'(exp_q.size()));
  endtask : mwr

  // ----------------------------------------------------------------
  // memory write watcher and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (host_ready === 1'b0)
      saw_full = 1'b1;
    if (rstn && mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      if (exp_q.size() == 0)
        chk("spare writes", 24'h0, 24'h1);
      else
        chk("write", exp_q.pop_front(), {mem_wr_addr, mem_wr_data});
    end
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    host_wr = 1'b0;
    host_cmd_sel = 1'b0;
    host_data = 8'h00;
    hold = 1'b0;
    line_pitch = 16'h0040 + 16'($random(seed) & 8'hff);
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    idle(1);
    chk("ready", 24'h1, {23'h0, host_ready});
    chk("reset regs", 24'h0, {23'h0, |{display_enable, display_attributes,
        cursor_width, cursor_height_style, cursor_direction, layer_overlay,
        cursor_address_low, cursor_address_high}});
    // setup command first; its parameters and others unused here
    send(1'b1, 8'h40);
    for (int i = 0; i < 8; i++) send(1'b0, 8'($random(seed)));
    send(1'b1, 8'h44);
    for (int i = 0; i < 10; i++) send(1'b0, 8'($random(seed)));
    idle(4);
    chk("ignored params", 24'h0, {16'h0, layer_overlay | display_enable});
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h01 : 8'($random(seed));
      send(1'b1, lhcd_pkg::CMD_OVERLAY);
      send(1'b0, v);
      idle(3);
      chk("overlay", {20'h0, v[3:0]}, {20'h0, layer_overlay[3:0]});
    end
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      send(1'b1, (i == 1) ? lhcd_pkg::CMD_DISP_ON : lhcd_pkg::CMD_DISP_OFF);
      send(1'b0, v);
      idle(3);
      chk("disp en", 24'(i == 1), {23'h0, display_enable[0]});
      chk("attrib", {16'h0, v}, {16'h0, display_attributes});
    end
    send(1'b1, lhcd_pkg::CMD_DISP_ON);
    send(1'b0, 8'h56);
    idle(3);
    chk("attrib", 24'h56, {16'h0, display_attributes});
    v = {7'h0, cursor_visible};
    for (int k = 0; k < 12 && cursor_visible === v[0]; k++) idle(1);
    v = {7'h0, cursor_visible};
    idle(3);
    chk("blink hold", {23'h0, v[0]}, {23'h0, cursor_visible});
    idle(1);
    chk("blink flip", {23'h0, ~v[0]}, {23'h0, cursor_visible});
    // off, then steady: both levels must hold without flashing
    for (int m = 0; m < 2; m++) begin
      send(1'b1, lhcd_pkg::CMD_DISP_ON);
      send(1'b0, 8'h54 | 8'(m));
      idle(3);
      chk("blink level", 24'(m), {23'h0, cursor_visible});
    end
    send(1'b1, lhcd_pkg::CMD_CSR_WRITE);
    send(1'b0, 8'h01);
    send(1'b0, 8'h10);
    idle(3);
    chk("csr addr", 24'h1001, {8'h0, cursor_address_high,
        cursor_address_low});
    send(1'b1, lhcd_pkg::CMD_CSR_WRITE);
    send(1'b0, 8'h22);
    // cut short by a new command: high half keeps its value
    send(1'b1, 8'h4f);
    idle(3);
    chk("csr addr", 24'h1022, {8'h0, cursor_address_high, cursor_address_low});
    chk("dir down", 24'h3, {16'h0, cursor_direction});
    send(1'b1, lhcd_pkg::CMD_CURSOR_SHAPE_CMD);
    send(1'b0, 8'h04);
    send(1'b0, 8'h86);
    idle(3);
    chk("form", 24'h486, {12'h0, cursor_width[3:0],
        cursor_height_style[7], 3'h0, cursor_height_style[3:0]});
    for (int d = 0; d < 4; d++) begin
      send(1'b1, lhcd_pkg::CMD_DIR_BASE + 8'(d));
      idle(3);
      chk("direction", 24'(d), {16'h0, cursor_direction});
    end
    // host clears text with 20h and graphics with 00h
    mwr(2'h0, 4, 1'b0, 8'h20);
    mwr(2'h3, 4, 1'b0, 8'h00);
    for (int d = 0; d < 4; d++) mwr(2'(d), 6, 1'b1, 8'h00);
    hold = 1'b1;
    fork
      mwr(2'h0, 40, 1'b1, 8'h00);
      begin
        wait (host_ready === 1'b0);
        repeat (20) @(posedge clk);
        #1;
        hold = 1'b0;
      end
    join
    chk("fifo full seen", 24'h1, {23'h0, saw_full});
    close_out();
  end
endmodule : lhcd_decoder_tb

// >>> tb/lhcd_mem_model.sv
// display memory side model: takes writes with random stalls
`timescale 1ns/100ps
module lhcd_mem_model #(
  parameter int SEED = 69535
) (
  input  wire logic clk,         // system clock
  input  wire logic rstn,        // sync reset, active low
  input  wire logic hold,        // long stall, lets the fifo fill
  output logic      mem_wr_ready // memory takes write
);
  integer seed = SEED;
  // one cycle in four stalls so held-valid paths are exercised
  always @(posedge clk) begin
    mem_wr_ready <= #1 rstn && !hold && ($random(seed) % 4 != 0);
  end
endmodule : lhcd_mem_model

// >>> verilog/lhcd_cursor_step.sv
// next cursor address for the selected movement direction
`timescale 1ns/100ps
module lhcd_cursor_step (
  input  wire logic [15:0] addr,   // current cursor address
  input  wire logic [1:0]  dir,    // movement direction
  input  wire logic [15:0] pitch,  // addresses per virtual line
  output logic      [15:0] next    // moved address
);
  // address space wraps at 16 bits, as the counter does
  always_comb begin
    unique case (dir)
      lhcd_pkg::DIR_RIGHT: next = addr + 16'h0001;
      lhcd_pkg::DIR_LEFT:  next = addr - 16'h0001;
      lhcd_pkg::DIR_UP:    next = addr - pitch;
      lhcd_pkg::DIR_DOWN:  next = addr + pitch;
    endcase
  end

endmodule : lhcd_cursor_step

// >>> verilog/lhcd_decoder.sv
// host command decoder of the character and graphics display controller
// Function
// - overlay parameter bits 1-0 pick combining
// - overlay bits 2,3 select text blocks
// - 58h clears, 59h sets display enable
// - attribute bits 1-0 select cursor blink
// - attribute bits hold three block enables
// - 46h loads cursor address, low first
// - 5dh first parameter holds cursor width
// - second parameter: height and block style
// - 4ch sets rightward cursor movement
// - 4fh sets downward cursor movement
// - 42h writes bytes, then moves cursor
`timescale 1ns/100ps
module lhcd_decoder #(
  parameter int BLINK_HALF_CYC = lhcd_pkg::BLINK_HALF_CYC,
  parameter int FIFO_DEPTH     = lhcd_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,                 // 100 mhz system clock
  input  wire logic        rstn,                // sync reset, active low
  input  wire logic        host_wr,             // host write strobe
  input  wire logic        host_cmd_sel,        // 1 command, 0 data
  input  wire logic [7:0]  host_data,           // host byte
  output logic             host_ready,          // host may write
  input  wire logic [15:0] line_pitch,          // addresses per line
  output logic             mem_wr_valid,        // memory write request
  output logic [15:0]      mem_wr_addr,         // memory write address
  output logic [7:0]       mem_wr_data,         // memory write byte
  input  wire logic        mem_wr_ready,        // memory takes write
  output logic [7:0]       display_enable,      // display on/off reg
  output logic [7:0]       display_attributes,  // blink and blocks
  output logic [7:0]       cursor_width,        // cursor width reg
  output logic [7:0]       cursor_height_style, // height and style
  output logic [7:0]       cursor_direction,    // movement direction
  output logic [7:0]       layer_overlay,       // layer combining
  output logic [7:0]       cursor_address_low,  // cursor addr low
  output logic [7:0]       cursor_address_high, // cursor addr high
  output logic             cursor_visible       // blink phase
);
  localparam int BW = lhcd_pkg::BYTE_W;

  // ------------------------------------------------------------
  // input fifo
  // ------------------------------------------------------------
  logic          fifo_valid, fifo_ready, fifo_is_cmd;
  logic [BW:0]   fifo_word;
  logic [BW-1:0] fifo_byte;
  logic          fifo_in_ready;

  lhcd_fifo #(
    .W     (BW + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (host_wr),
    .in_ready  (fifo_in_ready),
    .in_data   ({host_cmd_sel, host_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_word)
  );

  assign host_ready  = fifo_in_ready;
  assign fifo_is_cmd = fifo_word[BW];
  assign fifo_byte   = fifo_word[BW-1:0];

  // ------------------------------------------------------------
  // command and register state
  // ------------------------------------------------------------
  lhcd_pkg::lhcd_state_t state_r, state_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [1:0]  pidx_r, pidx_nxt;
  logic [7:0]  den_r, den_nxt, attr_r, attr_nxt;
  logic [7:0]  cw_r, cw_nxt, chs_r, chs_nxt;
  logic [7:0]  dir_r, dir_nxt, ovl_r, ovl_nxt;
  logic [15:0] cur_r, cur_nxt, cur_step;
  logic        mv_r, mv_nxt;
  logic [15:0] ma_r, ma_nxt;
  logic [7:0]  md_r, md_nxt;
  logic        pop;

  lhcd_cursor_step u_step (
    .addr  (cur_r),
    .dir   (dir_r[1:0]),
    .pitch (line_pitch),
    .next  (cur_step)
  );

  assign fifo_ready = (state_r == lhcd_pkg::ST_FETCH);
  assign pop        = fifo_valid && fifo_ready;

  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    pidx_nxt  = pidx_r;
    den_nxt   = den_r;
    attr_nxt  = attr_r;
    cw_nxt    = cw_r;
    chs_nxt   = chs_r;
    dir_nxt   = dir_r;
    ovl_nxt   = ovl_r;
    cur_nxt   = cur_r;
    mv_nxt    = mv_r;
    ma_nxt    = ma_r;
    md_nxt    = md_r;
    unique case (state_r)
      lhcd_pkg::ST_FETCH: begin
        if (pop && fifo_is_cmd) begin
          cmd_nxt  = fifo_byte;
          pidx_nxt = 2'h0;
          if (fifo_byte == lhcd_pkg::CMD_DISP_OFF) begin
            den_nxt[lhcd_pkg::DISP_EN_BIT] = 1'b0;
          end
          if (fifo_byte == lhcd_pkg::CMD_DISP_ON) begin
            den_nxt[lhcd_pkg::DISP_EN_BIT] = 1'b1;
          end
          if ((fifo_byte & lhcd_pkg::CMD_DIR_MASK)
              == lhcd_pkg::CMD_DIR_BASE) begin
            dir_nxt = {6'h00, fifo_byte[1:0]};
          end
        end else if (pop) begin
          if (pidx_r != 2'h3) begin
            pidx_nxt = pidx_r + 2'h1;
          end
          unique case (cmd_r)
            lhcd_pkg::CMD_OVERLAY: begin
              if (pidx_r == 2'h0) begin
                ovl_nxt = fifo_byte;
              end
            end
            lhcd_pkg::CMD_DISP_OFF, lhcd_pkg::CMD_DISP_ON: begin
              if (pidx_r == 2'h0) begin
                attr_nxt = fifo_byte;
              end
            end
            lhcd_pkg::CMD_CSR_WRITE: begin
              if (pidx_r == 2'h0) begin
                cur_nxt[7:0] = fifo_byte;
              end else if (pidx_r == 2'h1) begin
                cur_nxt[15:8] = fifo_byte;
              end
            end
            lhcd_pkg::CMD_CURSOR_SHAPE_CMD: begin
              if (pidx_r == 2'h0) begin
                cw_nxt = fifo_byte;
              end else if (pidx_r == 2'h1) begin
                chs_nxt = fifo_byte;
              end
            end
            lhcd_pkg::CMD_MEM_WRITE: begin
              mv_nxt    = 1'b1;
              ma_nxt    = cur_r;
              md_nxt    = fifo_byte;
              state_nxt = lhcd_pkg::ST_MWR;
            end
            default: begin
              // parameters of other commands are dropped
            end
          endcase
        end
      end
      lhcd_pkg::ST_MWR: begin
        if (mem_wr_ready) begin
          mv_nxt    = 1'b0;
          cur_nxt   = cur_step;
          state_nxt = lhcd_pkg::ST_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= lhcd_pkg::ST_FETCH;
      cmd_r   <= lhcd_pkg::REG_RESET;
      pidx_r  <= 2'h0;
      den_r   <= lhcd_pkg::REG_RESET;
      attr_r  <= lhcd_pkg::REG_RESET;
      cw_r    <= lhcd_pkg::REG_RESET;
      chs_r   <= lhcd_pkg::REG_RESET;
      dir_r   <= lhcd_pkg::REG_RESET;
      ovl_r   <= lhcd_pkg::REG_RESET;
      cur_r   <= lhcd_pkg::ADDR_RESET;
      mv_r    <= 1'b0;
      ma_r    <= lhcd_pkg::ADDR_RESET;
      md_r    <= lhcd_pkg::REG_RESET;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      pidx_r  <= pidx_nxt;
      den_r   <= den_nxt;
      attr_r  <= attr_nxt;
      cw_r    <= cw_nxt;
      chs_r   <= chs_nxt;
      dir_r   <= dir_nxt;
      ovl_r   <= ovl_nxt;
      cur_r   <= cur_nxt;
      mv_r    <= mv_nxt;
      ma_r    <= ma_nxt;
      md_r    <= md_nxt;
    end
  end

  // ------------------------------------------------------------
  // cursor blink
  // ------------------------------------------------------------
  logic [31:0] bcnt_r, bcnt_nxt;
  logic [1:0]  bph_r, bph_nxt;
  logic        vis_r, vis_nxt;

  always_comb begin
    bcnt_nxt = bcnt_r + 32'h1;
    bph_nxt  = bph_r;
    if (bcnt_r == 32'(BLINK_HALF_CYC - 1)) begin
      bcnt_nxt = 32'h0;
      bph_nxt  = bph_r + 2'h1;
    end
    unique case (attr_r[lhcd_pkg::BLINK_LSB +: 2])
      lhcd_pkg::BLINK_OFF:    vis_nxt = 1'b0;
      lhcd_pkg::BLINK_STEADY: vis_nxt = 1'b1;
      lhcd_pkg::BLINK_FAST:   vis_nxt = !bph_r[0];
      lhcd_pkg::BLINK_SLOW:   vis_nxt = !bph_r[1];
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bcnt_r <= 32'h0;
      bph_r  <= 2'h0;
      vis_r  <= 1'b0;
    end else begin
      bcnt_r <= bcnt_nxt;
      bph_r  <= bph_nxt;
      vis_r  <= vis_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign mem_wr_valid        = mv_r;
  assign mem_wr_addr         = ma_r;
  assign mem_wr_data         = md_r;
  assign display_enable      = den_r;
  assign display_attributes  = attr_r;
  assign cursor_width        = cw_r;
  assign cursor_height_style = chs_r;
  assign cursor_direction    = dir_r;
  assign layer_overlay       = ovl_r;
  assign cursor_address_low  = cur_r[7:0];
  assign cursor_address_high = cur_r[15:8];
  assign cursor_visible      = vis_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_DISP_OFF: assert property (@(posedge clk) disable iff (!rstn)
    pop && fifo_is_cmd && fifo_byte == lhcd_pkg::CMD_DISP_OFF
    |=> !display_enable[lhcd_pkg::DISP_EN_BIT])
    else $error("display not disabled by 58h");

  AST_DISP_ON: assert property (@(posedge clk) disable iff (!rstn)
    pop && fifo_is_cmd && fifo_byte == lhcd_pkg::CMD_DISP_ON
    |=> display_enable[lhcd_pkg::DISP_EN_BIT])
    else $error("display not enabled by 59h");

  AST_OVERLAY: assert property (@(posedge clk) disable iff (!rstn)
    pop && !fifo_is_cmd && cmd_r == lhcd_pkg::CMD_OVERLAY
    && pidx_r == 2'h0 |=> layer_overlay == $past(fifo_byte))
    else $error("overlay byte not stored");

  AST_ATTR: assert property (@(posedge clk) disable iff (!rstn)
    pop && !fifo_is_cmd && cmd_r == lhcd_pkg::CMD_DISP_ON
    && pidx_r == 2'h0 |=> display_attributes == $past(fifo_byte))
    else $error("attribute byte not stored");

  AST_CURSOR_WRITE_CMD: assert property (@(posedge clk) disable iff (!rstn)
    pop && !fifo_is_cmd && cmd_r == lhcd_pkg::CMD_CSR_WRITE
    && pidx_r == 2'h1
    |=> cursor_address_high == $past(fifo_byte)
    && cursor_address_low == $past(cursor_address_low))
    else $error("cursor high byte not loaded");

  AST_FORM: assert property (@(posedge clk) disable iff (!rstn)
    pop && !fifo_is_cmd && cmd_r == lhcd_pkg::CMD_CURSOR_SHAPE_CMD
    && pidx_r == 2'h1 |=> cursor_height_style == $past(fifo_byte))
    else $error("cursor height byte not stored");

  AST_DIR: assert property (@(posedge clk) disable iff (!rstn)
    pop && fifo_is_cmd
    && fifo_byte == (lhcd_pkg::CMD_DIR_BASE | 8'(lhcd_pkg::DIR_DOWN))
    |=> cursor_direction[1:0] == lhcd_pkg::DIR_DOWN)
    else $error("4fh did not select downward movement");

  AST_MWR: assert property (@(posedge clk) disable iff (!rstn)
    pop && !fifo_is_cmd && cmd_r == lhcd_pkg::CMD_MEM_WRITE
    |=> mem_wr_valid && mem_wr_addr == $past(cur_r)
    && mem_wr_data == $past(fifo_byte))
    else $error("memory write not issued at cursor");

  AST_ADVANCE: assert property (@(posedge clk) disable iff (!rstn)
    mem_wr_valid && mem_wr_ready && dir_r[1:0] == lhcd_pkg::DIR_DOWN
    |=> !mem_wr_valid && cur_r == $past(cur_r) + $past(line_pitch))
    else $error("cursor not moved down after write");

  AST_NEWCMD: assert property (@(posedge clk) disable iff (!rstn)
    pop && fifo_is_cmd |=> cmd_r == $past(fifo_byte) && pidx_r == 2'h0)
    else $error("command byte did not restart sequence");

  AST_BLINK: assert property (@(posedge clk) disable iff (!rstn)
    display_attributes[lhcd_pkg::BLINK_LSB +: 2] == lhcd_pkg::BLINK_STEADY
    ##1 display_attributes[lhcd_pkg::BLINK_LSB +: 2] == lhcd_pkg::BLINK_STEADY
    |-> cursor_visible)
    else $error("steady cursor not shown");

endmodule : lhcd_decoder

// >>> verilog/lhcd_fifo.sv
// byte fifo between host port and command decoder
`timescale 1ns/100ps
module lhcd_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rstn,      // sync reset, active low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // space left, registered
  input  wire logic [W-1:0] in_data,   // write word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // consumer takes word
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          full_r, full_nxt;
  // ready comes from its own flop so the port is registered
  logic          room_r, room_nxt;
  logic          push, pop;

  assign push      = in_valid && !full_r;
  assign pop       = out_valid && out_ready;
  assign in_ready  = room_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
    room_nxt = !full_nxt;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      full_r <= 1'b0;
      room_r <= 1'b1;
    end else begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      full_r <= full_nxt;
      room_r <= room_nxt;
    end
  end

  // storage has no reset, only pointers, count and flags do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

endmodule : lhcd_fifo
